// File: dv/uisc_host.sv
`timescale 1ns/1ps
module uisc_host
    import uisc_pkg::*;
(
    // host side of the register port
    input wire logic clk,
    output uisc_req_s req,
    output logic [DATA_W-1:0] line_control_reg,
    output logic [DATA_W-1:0] special_function_reg
);
    initial begin
        req = '0;
        line_control_reg = 8'h00;
        special_function_reg = 8'h00;
    end
    // key and enable set up (on) or taken away (off) ahead of the next access
    task automatic open_gate(input logic on);
        @(posedge clk);
        line_control_reg <= on ? LINE_CONTROL_KEY : 8'h03;
        special_function_reg <= on ? 8'h04 : 8'h00;
    endtask
    // one-cycle strobe, fields held through the taking edge
    task automatic access(input logic wr, input logic [7:0] d,
                          input logic [3:0] a);
        @(posedge clk);
        req <= '{wr_en: wr, rd_en: !wr, addr: a, wdata: d};
        @(posedge clk);
        req <= '0;
    endtask
endmodule

// File: dv/uisc_status_clear_tb.sv
`timescale 1ns/1ps
module uisc_status_clear_tb;
    import uisc_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    uisc_req_s req;
    logic [DATA_W-1:0] line_ctrl;
    logic [DATA_W-1:0] spec_func;
    logic [DATA_W-1:0] rdata;
    logic [DATA_W-1:0] stat;
    logic hit;
    uisc_events_s ev = '0;
    int errors = 0;
    int checks = 0;
    logic [7:0] exp;
    logic [7:0] hits = 8'h00;
    always #20 clk = ~clk;
    // hit is combinational, so it is counted at the edge that takes it
    always @(posedge clk) begin
        if (hit === 1'b1) begin
            hits <= hits + 8'h01;
        end
    end
    uisc_host host (.clk(clk), .req(req), .line_control_reg(line_ctrl),
        .special_function_reg(spec_func));
    uisc_status_clear dut (.clk(clk), .rst_n(rst_n), .req(req),
        .line_control_reg(line_ctrl), .special_function_reg(spec_func),
        .rdata(rdata), .hit(hit), .events(ev),
        .interrupt_status_clear_reg(stat));
    task automatic chk(input logic [7:0] seen, input logic [7:0] want);
        checks++;
        if (seen !== want) begin
            errors++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, want);
        end
    endtask
    task automatic close_out();
        if (errors == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        #1 chk(stat, INTERRUPT_STATUS_CLEAR_RESET);
        exp = 8'h00;
        // one source at a time, earlier bits must stay set
        for (int i = 0; i < NUM_SOURCES; i++) begin
            @(posedge clk);
            ev <= uisc_events_s'(7'h01 << i);
            @(posedge clk);
            ev <= '0;
            exp[i + 1] = 1'b1;
            #1 chk(stat, exp);
        end
        // clear while gate is shut must be ignored
        host.access(1'b1, 8'hff, INTERRUPT_STATUS_CLEAR_OFFSET);
        #1 chk(stat, exp);
        chk(hits, 8'h00);
        host.open_gate(1'b1);
        host.access(1'b1, 8'hfe, INTERRUPT_STATUS_CLEAR_OFFSET);
        #1 chk(stat, exp);
        chk(hits, 8'h01);
        host.access(1'b0, 8'h00, INTERRUPT_STATUS_CLEAR_OFFSET);
        #1 chk(rdata, exp);
        host.access(1'b1, 8'h01, 4'he);
        #1 chk(stat, exp);
        chk(hits, 8'h02);
        host.access(1'b1, 8'h01, INTERRUPT_STATUS_CLEAR_OFFSET);
        #1 chk(stat, 8'h00);
        host.access(1'b0, 8'h00, INTERRUPT_STATUS_CLEAR_OFFSET);
        #1 chk(rdata, 8'h00);
        chk(hits, 8'h04);
        // an event in the clear cycle outlives the clear
        exp = 8'h00;
        exp[BIT_MODEM] = 1'b1;
        fork
            host.access(1'b1, 8'h01, INTERRUPT_STATUS_CLEAR_OFFSET);
            begin
                @(posedge clk);
                ev.modem <= 1'b1;
                @(posedge clk);
                ev <= '0;
            end
        join
        #1 chk(stat, exp);
        host.access(1'b0, 8'h00, INTERRUPT_STATUS_CLEAR_OFFSET);
        #1 chk(rdata, exp);
        // closing the gate wipes the read latch one edge later
        host.open_gate(1'b0);
        @(posedge clk);
        #1 chk(rdata, 8'h00);
        chk(stat, exp);
        // reset in mid-run, with a status bit still set
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        #1 chk(stat, INTERRUPT_STATUS_CLEAR_RESET);
        @(posedge clk);
        ev.line_error <= 1'b1;
        @(posedge clk);
        ev <= '0;
        exp = 8'h00;
        exp[BIT_LINE_ERROR] = 1'b1;
        #1 chk(stat, exp);
        close_out();
    end
endmodule

// File: hw/uisc_status_clear.sv
`timescale 1ns/1ps
// Summary of operation
// [R1] status/clear register sits at channel offset 0x0f, resets to zero.
// [R2] reachable only while line control holds 0xbf and special bit 2 set.
// [R3] bit 7 shows an active cts/rts handshake change interrupt.
// [R4] bit 6 shows an active flow-off or special character interrupt.
// [R5] bit 5 shows an active modem-status interrupt.
// [R6] bit 4 shows an active transmit holding interrupt.
// [R7] bit 3 shows an active receiver timeout interrupt.
// [R8] bit 2 shows an active receive holding interrupt.
// [R9] bit 1 shows an active receive line error interrupt.
// [R10] writing one to bit 0 clears every status bit of the channel.
// [R11] the clear-all bit returns to zero itself; reads show zero there.
// [R12] special function bit 2 exposes the special register group.
// [R13] status bits set on source events and hold until clear-all.
module uisc_status_clear
    import uisc_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // register access from host port decoder
    input wire uisc_req_s req,
    input wire logic [DATA_W-1:0] line_control_reg,
    input wire logic [DATA_W-1:0] special_function_reg,
    output logic [DATA_W-1:0] rdata,
    output logic hit,
    // interrupt source events, one-cycle pulses
    input wire uisc_events_s events,
    // status view for the channel interrupt logic
    output logic [DATA_W-1:0] interrupt_status_clear_reg
);
    logic [NUM_SOURCES-1:0] status_reg;
    logic [NUM_SOURCES-1:0] status_next;
    logic [DATA_W-1:0] rdata_reg;
    logic [DATA_W-1:0] rdata_next;
    logic special_open;
    logic sel;
    logic clear_all;

    function automatic logic [DATA_W-1:0] pack_view(
        input logic [NUM_SOURCES-1:0] s);
        // clear-all position always reads zero
        pack_view = {s, 1'b0}; // [R11]
    endfunction

    // access gate: key in line control plus special access enable
    assign special_open = (line_control_reg == LINE_CONTROL_KEY) &&
        special_function_reg[SPECIAL_ACCESS_BIT]; // [R2] [R12]
    assign sel = special_open &&
        (req.addr == INTERRUPT_STATUS_CLEAR_OFFSET); // [R1]
    assign hit = sel && (req.wr_en || req.rd_en);
    assign clear_all = sel && req.wr_en &&
        req.wdata[BIT_CLEAR_ALL_STATUS]; // [R10]

    // clear first, so an event in the same cycle survives it
    always_comb begin
        status_next = status_reg;
        if (clear_all) begin
            status_next = '0; // [R10]
        end
        // order of struct fields matches bits 7 down to 1
        status_next = status_next |
            events; // [R3] [R4] [R5] [R6] [R7] [R8] [R9] [R13]
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            status_reg <=
                INTERRUPT_STATUS_CLEAR_RESET[DATA_W-1:BIT_LINE_ERROR]; // [R1]
        end else begin
            status_reg <= status_next;
        end
    end

    // a closed gate wipes the read latch, no stale status leaks out
    always_comb begin
        rdata_next = rdata_reg;
        if (sel && req.rd_en) begin
            rdata_next = pack_view(status_reg); // [R1]
        end else if (!special_open) begin
            rdata_next = '0; // [R2]
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata_reg <= '0;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign rdata = rdata_reg;
    assign interrupt_status_clear_reg = pack_view(status_reg);

    a_reset_zero: assert property (@(posedge clk)
        !rst_n |=> interrupt_status_clear_reg == '0) // [R1]
        else $error("status not zero after reset");

    // only-grows view of the status: bits may be set, never dropped
    sequence s_status_kept;
        (interrupt_status_clear_reg & $past(interrupt_status_clear_reg)) ==
            $past(interrupt_status_clear_reg);
    endsequence

    sequence s_read_cmd;
        sel && req.rd_en;
    endsequence

    // a shut gate must also keep a clear write from reaching the status
    a_gate_closed: assert property (@(posedge clk) disable iff (!rst_n)
        (line_control_reg != LINE_CONTROL_KEY) |->
        !hit ##1 s_status_kept) // [R2]
        else $error("access taken without line control key");

    a_gate_enable: assert property (@(posedge clk) disable iff (!rst_n)
        !special_function_reg[SPECIAL_ACCESS_BIT] |->
        !hit ##1 s_status_kept) // [R12]
        else $error("access taken without special enable");

    a_handshake_set: assert property (@(posedge clk) disable iff (!rst_n)
        events.handshake_change |=>
        interrupt_status_clear_reg[BIT_HANDSHAKE_CHANGE]) // [R3]
        else $error("bit 7 not set on handshake change");

    a_flowoff_set: assert property (@(posedge clk) disable iff (!rst_n)
        events.flow_off_special |=>
        interrupt_status_clear_reg[BIT_FLOW_OFF_SPECIAL]) // [R4]
        else $error("bit 6 not set on flow-off");

    a_modem_set: assert property (@(posedge clk) disable iff (!rst_n)
        events.modem |=> interrupt_status_clear_reg[BIT_MODEM]) // [R5]
        else $error("bit 5 not set on modem event");

    a_txhold_set: assert property (@(posedge clk) disable iff (!rst_n)
        events.transmit_holding |=>
        interrupt_status_clear_reg[BIT_TRANSMIT_HOLDING]) // [R6]
        else $error("bit 4 not set on transmit holding");

    a_timeout_set: assert property (@(posedge clk) disable iff (!rst_n)
        events.rx_timeout |=>
        interrupt_status_clear_reg[BIT_RX_TIMEOUT]) // [R7]
        else $error("bit 3 not set on timeout");

    a_rxhold_set: assert property (@(posedge clk) disable iff (!rst_n)
        events.receive_holding |=>
        interrupt_status_clear_reg[BIT_RECEIVE_HOLDING]) // [R8]
        else $error("bit 2 not set on receive holding");

    a_lineerr_set: assert property (@(posedge clk) disable iff (!rst_n)
        events.line_error |=>
        interrupt_status_clear_reg[BIT_LINE_ERROR]) // [R9]
        else $error("bit 1 not set on line error");

    sequence s_clear_cmd;
        clear_all && (events == '0);
    endsequence

    a_clear_all: assert property (@(posedge clk) disable iff (!rst_n)
        s_clear_cmd |=> interrupt_status_clear_reg == '0) // [R10]
        else $error("clear-all left status set");

    a_cmd_bit_zero: assert property (@(posedge clk) disable iff (!rst_n)
        (sel && req.rd_en) |=> !rdata[BIT_CLEAR_ALL_STATUS]) // [R11]
        else $error("clear-all bit read back as one");

    a_status_hold: assert property (@(posedge clk) disable iff (!rst_n)
        !clear_all |=> (interrupt_status_clear_reg &
        $past(interrupt_status_clear_reg)) ==
        $past(interrupt_status_clear_reg)) // [R13]
        else $error("status bit dropped without clear-all");

    a_reset_rdata: assert property (@(posedge clk)
        !rst_n |=> rdata == '0) // [R1]
        else $error("read data not zero after reset");

    a_bit0_view: assert property (@(posedge clk) disable iff (!rst_n)
        !interrupt_status_clear_reg[BIT_CLEAR_ALL_STATUS]) // [R11]
        else $error("clear-all bit shows one in status view");

    a_read_value: assert property (@(posedge clk) disable iff (!rst_n)
        s_read_cmd |=> rdata == $past(interrupt_status_clear_reg)) // [R1]
        else $error("read data differs from status");

    // an event in the clear cycle keeps its bit set right after the clear
    a_event_wins: assert property (@(posedge clk) disable iff (!rst_n)
        clear_all |=>
        interrupt_status_clear_reg[DATA_W-1:BIT_LINE_ERROR] ==
        $past(events)) // [R10] [R13]
        else $error("event lost in the clear cycle");

    a_set_exact: assert property (@(posedge clk) disable iff (!rst_n)
        !clear_all |=>
        interrupt_status_clear_reg[DATA_W-1:BIT_LINE_ERROR] ==
        ($past(interrupt_status_clear_reg[DATA_W-1:BIT_LINE_ERROR]) |
        $past(events))) // [R13]
        else $error("status differs from held bits and events");

    // bits 7 down to 1 are hardware-set only, data there is ignored
    sequence s_plain_write;
        sel && req.wr_en && !req.wdata[BIT_CLEAR_ALL_STATUS] &&
        (events == '0);
    endsequence

    a_write_ignored: assert property (@(posedge clk) disable iff (!rst_n)
        s_plain_write |=> interrupt_status_clear_reg ==
        $past(interrupt_status_clear_reg)) // [R13]
        else $error("write changed hardware-set status bits");

    a_rdata_hold: assert property (@(posedge clk) disable iff (!rst_n)
        special_open && !(sel && req.rd_en) |=> $stable(rdata)) // [R2]
        else $error("read data moved without a read");

    a_rdata_closed: assert property (@(posedge clk) disable iff (!rst_n)
        !special_open |=> rdata == '0) // [R2]
        else $error("read data kept after gate closed");

    a_other_offset: assert property (@(posedge clk) disable iff (!rst_n)
        special_open && req.wr_en &&
        (req.addr != INTERRUPT_STATUS_CLEAR_OFFSET) |->
        !hit ##1 s_status_kept) // [R1]
        else $error("write to another offset touched status");
endmodule

// File: shared/uisc_pkg.sv
package uisc_pkg;
    // register port of the channel as seen from the host-side decoder
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam logic [ADDR_W-1:0] INTERRUPT_STATUS_CLEAR_OFFSET = 4'hf;
    localparam logic [DATA_W-1:0] INTERRUPT_STATUS_CLEAR_RESET = 8'h00;
    localparam logic [DATA_W-1:0] LINE_CONTROL_KEY = 8'hbf;
    localparam int SPECIAL_ACCESS_BIT = 2;
    // status field positions
    localparam int BIT_HANDSHAKE_CHANGE = 7;
    localparam int BIT_FLOW_OFF_SPECIAL = 6;
    localparam int BIT_MODEM = 5;
    localparam int BIT_TRANSMIT_HOLDING = 4;
    localparam int BIT_RX_TIMEOUT = 3;
    localparam int BIT_RECEIVE_HOLDING = 2;
    localparam int BIT_LINE_ERROR = 1;
    localparam int BIT_CLEAR_ALL_STATUS = 0;
    localparam int NUM_SOURCES = 7;

    typedef struct packed {
        logic handshake_change;
        logic flow_off_special;
        logic modem;
        logic transmit_holding;
        logic rx_timeout;
        logic receive_holding;
        logic line_error;
    } uisc_events_s;

    typedef struct packed {
        logic wr_en;
        logic rd_en;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } uisc_req_s;
endpackage
